// ---- cwors_pkg.sv ----
// cwors_pkg: constants, types and decode helpers of the config word / oscillator / reset block
package cwors_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	// watchdog rc period is nominal only; the rc drifts over supply and temperature
	localparam int RC_PERIOD_NS    = 1000;
	localparam int HOLD_LONG_MS     = 18;
	localparam int HOLD_SHORT_US    = 1125;
	localparam int NS_PER_MS        = 1000000;
	localparam int NS_PER_US        = 1000;
	localparam int HOLD_LONG_TICKS  = (HOLD_LONG_MS * NS_PER_MS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
	localparam int HOLD_SHORT_TICKS = (HOLD_SHORT_US * NS_PER_US + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
	localparam int CNT_W           = 16;
	typedef logic [CNT_W-1:0] cwors_cnt_t;

	// ************************************************************
	// configuration word layout
	// ************************************************************
	localparam int CFG_W = 12;
	typedef logic [CFG_W-1:0] cwors_cfg_t;
	localparam cwors_cfg_t UNIMP8_MASK  = 12'hfc0;
	localparam cwors_cfg_t UNIMP14_MASK = 12'hf80;
	localparam int P8_FREQ      = 5;
	localparam int P8_RPEN      = 4;
	localparam int P8_PROT      = 3;
	localparam int P8_WDEN      = 2;
	localparam int P8_FOSC_MSB  = 1;
	localparam int P14_FREQ     = 6;
	localparam int P14_RPEN     = 5;
	localparam int P14_PROT     = 4;
	localparam int P14_WDEN     = 3;
	localparam int P14_FOSC_MSB = 2;
	localparam int FOSC_LSB     = 0;

	localparam logic [1:0] F8_LOWP = 2'h0;
	localparam logic [1:0] F8_STD  = 2'h1;
	localparam logic [1:0] F8_INT  = 2'h2;
	localparam logic [2:0] F14_LOWP  = 3'h0;
	localparam logic [2:0] F14_STD   = 3'h1;
	localparam logic [2:0] F14_FAST  = 3'h2;
	localparam logic [2:0] F14_EXTC  = 3'h3;
	localparam logic [2:0] F14_INTIO = 3'h4;
	localparam logic [2:0] F14_INTCO = 3'h5;
	localparam logic [2:0] F14_RCIO  = 3'h6;

	typedef enum logic [2:0] {
		LOW_POWER_CRYSTAL, STANDARD_CRYSTAL, HIGH_SPEED_CRYSTAL,
		EXTERNAL_CLOCK_IN, INTERNAL_OSC, EXTERNAL_RC_OSC
	} cwors_osc_e;

	typedef enum logic [2:0] {ST_CAPTURE, ST_LOAD, ST_HOLD, ST_EXT, ST_RUN} cwors_state_e;

	typedef struct packed {
		cwors_osc_e mode;
		logic       hold_long;
		logic       clock_out_pin_fn;
		logic       port_bit_osc_out_pin;
	} cwors_osc_s;

	typedef struct packed {
		logic       int_osc_freq_sel;
		logic       ext_reset_pin_en;
		logic       code_protect_n;
		logic       watchdog_en;
		cwors_osc_s osc;
	} cwors_dec_s;

	typedef struct packed {
		logic       por_pend;
		logic       ext_reset_pin_en;
		logic       watchdog_en;
		logic       code_protect_n;
		logic       var14;
		logic       timer_done;
		logic       core_run;
		logic       port_bit_osc_out_pin;
		logic       clock_out_pin_fn;
		logic       hold_long;
		cwors_osc_e mode;
	} cwors_stat_s;

	// ************************************************************
	// register bus
	// ************************************************************
	typedef logic [31:0] cwors_word_t;
	localparam logic [7:0] REG_CFG    = 8'h00;
	localparam logic [7:0] REG_STAT   = 8'h04;
	localparam logic [7:0] REG_CTRL   = 8'h08;
	localparam int         CTRL_SOFT  = 0;
	localparam int         HTRANS_ACT = 1;
	localparam logic       HRESP_OKAY = 1'h0;

	function automatic cwors_osc_s osc_set(cwors_osc_e m, logic lng, logic co, logic pb);
		cwors_osc_s o;
		o.mode             = m;
		o.hold_long        = lng;
		o.clock_out_pin_fn = co;
		o.port_bit_osc_out_pin    = pb;
		return o;
	endfunction

	function automatic cwors_dec_s decode(cwors_cfg_t w, logic v14);
		cwors_dec_s d;
		d.int_osc_freq_sel = v14 ? w[P14_FREQ] : w[P8_FREQ];
		d.ext_reset_pin_en = v14 ? w[P14_RPEN] : w[P8_RPEN];
		d.code_protect_n   = v14 ? w[P14_PROT] : w[P8_PROT];
		d.watchdog_en      = v14 ? w[P14_WDEN] : w[P8_WDEN];
		if (v14) begin
			case (w[P14_FOSC_MSB:FOSC_LSB])
				F14_LOWP:  d.osc = osc_set(LOW_POWER_CRYSTAL, 1'h1, 1'h0, 1'h0);
				F14_STD:   d.osc = osc_set(STANDARD_CRYSTAL, 1'h1, 1'h0, 1'h0);
				F14_FAST:  d.osc = osc_set(HIGH_SPEED_CRYSTAL, 1'h1, 1'h0, 1'h0);
				F14_EXTC:  d.osc = osc_set(EXTERNAL_CLOCK_IN, 1'h0, 1'h0, 1'h1);
				F14_INTIO: d.osc = osc_set(INTERNAL_OSC, 1'h0, 1'h0, 1'h1);
				F14_INTCO: d.osc = osc_set(INTERNAL_OSC, 1'h0, 1'h1, 1'h0);
				F14_RCIO:  d.osc = osc_set(EXTERNAL_RC_OSC, 1'h0, 1'h0, 1'h1);
				default:   d.osc = osc_set(EXTERNAL_RC_OSC, 1'h0, 1'h1, 1'h0);
			endcase
		end else begin
			case (w[P8_FOSC_MSB:FOSC_LSB])
				F8_LOWP: d.osc = osc_set(LOW_POWER_CRYSTAL, 1'h1, 1'h0, 1'h0);
				F8_STD:  d.osc = osc_set(STANDARD_CRYSTAL, 1'h1, 1'h0, 1'h0);
				F8_INT:  d.osc = osc_set(INTERNAL_OSC, 1'h0, 1'h0, 1'h1);
				default: d.osc = osc_set(EXTERNAL_RC_OSC, 1'h0, 1'h0, 1'h1);
			endcase
		end
		return d;
	endfunction

	function automatic cwors_cfg_t readback(cwors_cfg_t w, logic v14);
		return w | (v14 ? UNIMP14_MASK : UNIMP8_MASK);
	endfunction

endpackage

// ---- cwors_hold_timer.sv ----
// cwors_hold_timer: reset hold timer counting ticks of the watchdog rc oscillator
module cwors_hold_timer #(
	parameter cwors_pkg::cwors_cnt_t LONG_TICKS  = cwors_pkg::cwors_cnt_t'(cwors_pkg::HOLD_LONG_TICKS),
	parameter cwors_pkg::cwors_cnt_t SHORT_TICKS = cwors_pkg::cwors_cnt_t'(cwors_pkg::HOLD_SHORT_TICKS)
) (
	input  wire logic clk,      // system clock
	input  wire logic rst_n,    // async reset, active low
	input  wire logic start,    // restart the count
	input  wire logic use_long, // long delay for crystal modes
	input  wire logic tick,     // one rc period elapsed
	output logic      done      // delay has elapsed
);
	cwors_pkg::cwors_cnt_t cnt_q;
	cwors_pkg::cwors_cnt_t tgt_q;
	cwors_pkg::cwors_cnt_t cnt_inc;
	logic                  done_q;

	assign cnt_inc = cnt_q + cwors_pkg::cwors_cnt_t'(1);
	assign done    = done_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			tgt_q  <= SHORT_TICKS;
			done_q <= 1'h0;
		end else if (start) begin
			cnt_q  <= '0;
			tgt_q  <= use_long ? LONG_TICKS : SHORT_TICKS;
			done_q <= 1'h0;
		end else if (tick && !done_q) begin
			cnt_q  <= cnt_inc;
			done_q <= (cnt_inc >= tgt_q);
		end
	end
endmodule // cwors_hold_timer

// ---- cwors_top.sv ----
// cwors_top: configuration word decoder, reset hold sequencing and register slave

// How it works
// - a 12-bit configuration word selects oscillator, watchdog, reset pin, protection, frequency
// - 8-pin variant: word bits 11..6 read back as ones
// - 14-pin variant: word bits 11..7 read back as ones
// - frequency select bit chooses 8 MHz when set, 4 MHz when clear
// - reset pin enable: pin is active-low reset, else plain input
// - protection bit set disables code protection, clear enables it
// - watchdog enable bit alone turns the watchdog on or off
// - watchdog runs from its own rc oscillator, whatever the system clock
// - 8-pin codes: low-power, standard crystal long delay; internal, rc short
// - 14-pin codes 000..010: three crystal modes, long delay
// - 14-pin code 011: external clock, short delay, second pin is port
// - 14-pin codes 100, 101: internal oscillator; port bit or clock out
// - 14-pin codes 110, 111: external rc; port bit or clock out
// - crystal modes: hold timer runs after every reset
// - other modes: short hold delay only at power-up
// - two oscillator bits on 8-pin, three selecting six modes on 14-pin
module cwors_top #(
	parameter cwors_pkg::cwors_cnt_t LONG_TICKS  = cwors_pkg::cwors_cnt_t'(cwors_pkg::HOLD_LONG_TICKS),
	parameter cwors_pkg::cwors_cnt_t SHORT_TICKS = cwors_pkg::cwors_cnt_t'(cwors_pkg::HOLD_SHORT_TICKS)
) (
	input  wire logic              SYS_CLK,          // 40 MHz system clock
	input  wire logic              RESET_N,          // power-on reset, async
	input  wire logic [11:0]       CFG_WORD,         // nonvolatile configuration word
	input  wire logic              VARIANT_14,       // strap: 1 = 14-pin variant
	input  wire logic              WDOG_RC_CLK,      // watchdog rc oscillator
	input  wire logic              EXT_RESET_N_PIN,  // shared reset / port pin
	input  wire logic              HSEL,             // slave select
	input  wire logic [31:0]       HADDR,            // byte address
	input  wire logic [1:0]        HTRANS,           // transfer type
	input  wire logic              HWRITE,           // write when high
	input  wire logic [2:0]        HSIZE,            // word only
	input  wire logic [31:0]       HWDATA,           // write data
	input  wire logic              HREADY,           // bus ready
	output logic                   HREADYOUT,        // slave ready
	output logic                   HRESP,            // always okay
	output logic [31:0]            HRDATA,           // read data
	output logic                   CORE_RESET_N,     // core reset, active low
	output cwors_pkg::cwors_osc_e  OSC_MODE,         // selected oscillator
	output logic                   INT_OSC_FREQ_SEL, // 1 = 8 MHz internal
	output logic                   EXT_RESET_PIN_EN, // pin acts as reset
	output logic                   CODE_PROTECT_N,   // 0 = protection on
	output logic                   WATCHDOG_EN,      // watchdog enabled
	output logic                   WATCHDOG_TICK,    // watchdog count pulse
	output logic                   CLOCK_OUT_PIN_FN, // second pin drives clock out
	output logic                   PORT_BIT_OSC_OUT_PIN,    // second pin is port bit
	output logic                   PORT_BIT_RESET_PIN // shared pin input value, held high while the pin acts as reset
);
	// ************************************************************
	// synchronisers
	// ************************************************************
	logic                    e1_q, e2_q, e3_q, pin_f_q;
	logic                    r1_q, r2_q, r3_q, rc_f_q;
	wire                     rc_tick = (r2_q == r3_q) && r2_q && !rc_f_q;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{e1_q, e2_q, e3_q, pin_f_q} <= 4'hf;
			{r1_q, r2_q, r3_q, rc_f_q}  <= 4'h0;
		end else begin
			{e1_q, e2_q, e3_q} <= {EXT_RESET_N_PIN, e1_q, e2_q};
			{r1_q, r2_q, r3_q} <= {WDOG_RC_CLK, r1_q, r2_q};
			if (e2_q == e3_q)
				pin_f_q <= e2_q;
			if (r2_q == r3_q)
				rc_f_q <= r2_q;
		end
	end

	// ************************************************************
	// configuration capture and decode
	// ************************************************************
	cwors_pkg::cwors_state_e state_q, state_d;
	cwors_pkg::cwors_dec_s   dec_q;
	cwors_pkg::cwors_cfg_t   rb_q;
	logic                    var14_q;
	logic                    cfg_ok_q;
	logic                    por_pend_q;
	logic                    soft_pulse_q;
	logic                    core_rel_q;
	logic                    wdog_tick_q;
	logic                    prt_q;
	logic                    timer_done;
	wire                     capture    = (state_q == cwors_pkg::ST_CAPTURE);
	wire                     ext_active = dec_q.ext_reset_pin_en && !pin_f_q;
	wire                     rst_src    = cfg_ok_q && (soft_pulse_q || ext_active);
	wire                     need_timer = dec_q.osc.hold_long || por_pend_q;
	wire                     timer_start = (state_q == cwors_pkg::ST_LOAD);

	// word and variant are caught once, after power-on release only
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dec_q    <= '0;
			rb_q     <= '0;
			var14_q  <= 1'h0;
			cfg_ok_q <= 1'h0;
		end else if (capture) begin
			dec_q    <= cwors_pkg::decode(CFG_WORD, VARIANT_14);
			rb_q     <= cwors_pkg::readback(CFG_WORD, VARIANT_14);
			var14_q  <= VARIANT_14;
			cfg_ok_q <= 1'h1;
		end
	end

	// ************************************************************
	// reset sequencing
	// ************************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			cwors_pkg::ST_CAPTURE: state_d = cwors_pkg::ST_LOAD;
			cwors_pkg::ST_LOAD:    state_d = cwors_pkg::ST_HOLD;
			cwors_pkg::ST_HOLD: begin
				if (rst_src)
					state_d = cwors_pkg::ST_EXT;
				else if (timer_done)
					state_d = cwors_pkg::ST_RUN;
			end
			cwors_pkg::ST_EXT: begin
				if (!rst_src)
					state_d = need_timer ? cwors_pkg::ST_LOAD : cwors_pkg::ST_RUN;
			end
			cwors_pkg::ST_RUN: begin
				if (rst_src)
					state_d = cwors_pkg::ST_EXT;
			end
			default: state_d = cwors_pkg::ST_CAPTURE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q    <= cwors_pkg::ST_CAPTURE;
			core_rel_q <= 1'h0;
			por_pend_q <= 1'h1;
		end else begin
			state_q    <= state_d;
			core_rel_q <= (state_d == cwors_pkg::ST_RUN);
			// power-up delay is owed until it has once run to the end
			if (state_q == cwors_pkg::ST_HOLD && state_d == cwors_pkg::ST_RUN)
				por_pend_q <= 1'h0;
		end
	end

	cwors_hold_timer #(
		.LONG_TICKS  (LONG_TICKS),
		.SHORT_TICKS (SHORT_TICKS)
	) u_timer (
		.clk      (SYS_CLK),
		.rst_n    (RESET_N),
		.start    (timer_start),
		.use_long (dec_q.osc.hold_long),
		.tick     (rc_tick),
		.done     (timer_done)
	);

	// watchdog counts rc ticks, never the selected system oscillator
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wdog_tick_q <= 1'h0;
			prt_q       <= 1'h1;
		end else begin
			wdog_tick_q <= rc_tick && dec_q.watchdog_en;
			prt_q      <= pin_f_q || dec_q.ext_reset_pin_en;
		end
	end

	assign CORE_RESET_N       = core_rel_q;
	assign OSC_MODE           = dec_q.osc.mode;
	assign INT_OSC_FREQ_SEL   = dec_q.int_osc_freq_sel;
	assign EXT_RESET_PIN_EN   = dec_q.ext_reset_pin_en;
	assign CODE_PROTECT_N     = dec_q.code_protect_n;
	assign WATCHDOG_EN        = dec_q.watchdog_en;
	assign WATCHDOG_TICK      = wdog_tick_q;
	assign CLOCK_OUT_PIN_FN   = dec_q.osc.clock_out_pin_fn;
	assign PORT_BIT_OSC_OUT_PIN      = dec_q.osc.port_bit_osc_out_pin;
	assign PORT_BIT_RESET_PIN = prt_q;

	// ************************************************************
	// bus slave
	// ************************************************************
	// zero wait states: read data is prepared during the address phase
	cwors_pkg::cwors_stat_s stat;
	cwors_pkg::cwors_word_t rd_mux;
	cwors_pkg::cwors_word_t rdata_q;
	logic [7:0]             waddr_q;
	logic                   wpend_q;
	wire                    ahb_go   = HSEL && HREADY && HTRANS[cwors_pkg::HTRANS_ACT];
	wire [7:0]              addr_lo  = HADDR[7:0];
	wire                    addr_hi0 = (HADDR[31:8] == '0);
	wire                    ctrl_wr  = wpend_q && (waddr_q == cwors_pkg::REG_CTRL);

	assign stat.por_pend         = por_pend_q;
	assign stat.ext_reset_pin_en = dec_q.ext_reset_pin_en;
	assign stat.watchdog_en      = dec_q.watchdog_en;
	assign stat.code_protect_n   = dec_q.code_protect_n;
	assign stat.var14            = var14_q;
	assign stat.timer_done       = timer_done;
	assign stat.core_run         = core_rel_q;
	assign stat.port_bit_osc_out_pin    = dec_q.osc.port_bit_osc_out_pin;
	assign stat.clock_out_pin_fn = dec_q.osc.clock_out_pin_fn;
	assign stat.hold_long        = dec_q.osc.hold_long;
	assign stat.mode             = dec_q.osc.mode;

	assign rd_mux = !addr_hi0                      ? '0 :
			(addr_lo == cwors_pkg::REG_CFG)  ? cwors_pkg::cwors_word_t'(rb_q) :
			(addr_lo == cwors_pkg::REG_STAT) ? cwors_pkg::cwors_word_t'(stat) : '0;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_q      <= '0;
			waddr_q      <= '0;
			wpend_q      <= 1'h0;
			soft_pulse_q <= 1'h0;
		end else begin
			wpend_q      <= ahb_go && HWRITE;
			waddr_q      <= addr_hi0 ? addr_lo : cwors_pkg::REG_STAT;
			soft_pulse_q <= ctrl_wr && HWDATA[cwors_pkg::CTRL_SOFT];
			if (ahb_go && !HWRITE)
				rdata_q <= rd_mux;
		end
	end

	assign HREADYOUT = 1'h1;
	assign HRESP     = cwors_pkg::HRESP_OKAY;
	assign HRDATA    = rdata_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_ext_release;
		(state_q == cwors_pkg::ST_EXT) && !rst_src;
	endsequence

	sequence s_timer_end;
		(state_q == cwors_pkg::ST_HOLD) && !rst_src && timer_done;
	endsequence

	readback_8pin_a: assert property (cfg_ok_q && !var14_q |->
		(rb_q & cwors_pkg::UNIMP8_MASK) == cwors_pkg::UNIMP8_MASK)
		else $error("8-pin readback upper bits not ones");
	readback_14pin_a: assert property (cfg_ok_q && var14_q |->
		(rb_q & cwors_pkg::UNIMP14_MASK) == cwors_pkg::UNIMP14_MASK)
		else $error("14-pin readback upper bits not ones");
	freq_select_a: assert property (cfg_ok_q |-> INT_OSC_FREQ_SEL ==
		(var14_q ? rb_q[cwors_pkg::P14_FREQ] : rb_q[cwors_pkg::P8_FREQ]))
		else $error("frequency select does not follow word");
	pin_reset_a: assert property (EXT_RESET_PIN_EN && !pin_f_q |=> !CORE_RESET_N)
		else $error("reset pin low did not hold core");
	pin_ignored_a: assert property ((state_q == cwors_pkg::ST_RUN) && !EXT_RESET_PIN_EN
		&& !soft_pulse_q |=> CORE_RESET_N)
		else $error("core reset without an enabled source");
	code_protect_a: assert property (cfg_ok_q |-> CODE_PROTECT_N ==
		(var14_q ? rb_q[cwors_pkg::P14_PROT] : rb_q[cwors_pkg::P8_PROT]))
		else $error("code protect does not follow word");
	wdog_enable_a: assert property (cfg_ok_q |-> WATCHDOG_EN ==
		(var14_q ? rb_q[cwors_pkg::P14_WDEN] : rb_q[cwors_pkg::P8_WDEN]))
		else $error("watchdog enable does not follow word");
	wdog_rc_tick_a: assert property (rc_tick && WATCHDOG_EN |=> WATCHDOG_TICK)
		else $error("watchdog missed an rc tick");
	mode_8pin_a: assert property (cfg_ok_q && !var14_q |->
		!(OSC_MODE inside {cwors_pkg::HIGH_SPEED_CRYSTAL, cwors_pkg::EXTERNAL_CLOCK_IN}))
		else $error("8-pin variant decoded a 14-pin mode");
	crystal_long_a: assert property (cfg_ok_q && (OSC_MODE inside {cwors_pkg::LOW_POWER_CRYSTAL,
		cwors_pkg::STANDARD_CRYSTAL, cwors_pkg::HIGH_SPEED_CRYSTAL}) |-> dec_q.osc.hold_long)
		else $error("crystal mode without long delay");
	ext_clock_a: assert property (OSC_MODE == cwors_pkg::EXTERNAL_CLOCK_IN |->
		PORT_BIT_OSC_OUT_PIN && !dec_q.osc.hold_long)
		else $error("external clock mode decoded wrongly");
	clock_out_a: assert property (CLOCK_OUT_PIN_FN |-> var14_q &&
		rb_q[cwors_pkg::P14_FOSC_MSB] && rb_q[cwors_pkg::FOSC_LSB] && !PORT_BIT_OSC_OUT_PIN)
		else $error("clock out on a code without it");
	crystal_rerun_a: assert property (s_ext_release ##0 dec_q.osc.hold_long |=>
		(state_q == cwors_pkg::ST_LOAD) ##1 (state_q == cwors_pkg::ST_HOLD) && !CORE_RESET_N)
		else $error("crystal mode skipped hold timer");
	short_skip_a: assert property (s_ext_release ##0 !need_timer |=> CORE_RESET_N)
		else $error("non-crystal reset was delayed");
	timer_release_a: assert property (s_timer_end |=> CORE_RESET_N)
		else $error("core not released at timer end");
	hold_in_reset_a: assert property ((state_q == cwors_pkg::ST_HOLD) && !timer_done
		|-> !CORE_RESET_N)
		else $error("core released before timer end");
	static_word_a: assert property (cfg_ok_q && $past(cfg_ok_q) |->
		$stable(rb_q) && $stable(dec_q))
		else $error("configuration resampled");
endmodule // cwors_top

// ---- cwors_rc_model.sv ----
// cwors_rc_model: watchdog rc oscillator standing at the far side of the block
module cwors_rc_model (
	input  wire logic slow,   // stretch the rc period
	output logic      rc_clk  // rc oscillator output
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// free running rc
	// ************************************************************
	// never stops between resets: the timer must see a continuous source
	initial begin
		rc_clk = 1'h0;
		forever #(slow ? 300 : 100) rc_clk = ~rc_clk;
	end
endmodule // cwors_rc_model

// ---- testbench.sv ----
// testbench: self-checking bench for the config word decoder and reset hold sequencing
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic                  clk, rst_n, v14, pin, hsel, hwrite, slow, rc;
	logic [11:0]           cfg;
	logic [31:0]           haddr, hwdata, hrdata, rd;
	logic [1:0]            htrans;
	logic                  hready, hresp, core_n, freq, rpen, prot_n, wden, wtick, co, pb, rpin;
	cwors_pkg::cwors_osc_e mode;
	int                    errors, n_compared, cyc, n_rel;

	// short counts keep each hold window to tens of cycles
	cwors_top #(.LONG_TICKS(16'h0008), .SHORT_TICKS(16'h0004)) i_cwors_top (
		.SYS_CLK(clk), .RESET_N(rst_n), .CFG_WORD(cfg), .VARIANT_14(v14), .WDOG_RC_CLK(rc),
		.EXT_RESET_N_PIN(pin), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
		.HRDATA(hrdata), .CORE_RESET_N(core_n), .OSC_MODE(mode), .INT_OSC_FREQ_SEL(freq),
		.EXT_RESET_PIN_EN(rpen), .CODE_PROTECT_N(prot_n), .WATCHDOG_EN(wden),
		.WATCHDOG_TICK(wtick), .CLOCK_OUT_PIN_FN(co), .PORT_BIT_OSC_OUT_PIN(pb),
		.PORT_BIT_RESET_PIN(rpin)
	);
	cwors_rc_model i_cwors_rc_model (.slow(slow), .rc_clk(rc));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		d = hrdata;
		check("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wait_rel();
		n_rel = 0;
		@(posedge clk);
		while (core_n !== 1'h1 && n_rel < 400) begin
			@(posedge clk);
			n_rel++;
		end
	endtask

	task automatic boot(input logic [11:0] w, input logic v);
		cfg <= w;
		v14 <= v;
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		wait_rel();
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic decode_all();
		logic [2:0]  m14 [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
		logic [2:0]  m8 [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
		logic [2:0]  c;
		logic [11:0] w;
		logic        v;
		logic        lg;
		for (int i = 0; i < 12; i++) begin
			v = (i < 8);
			c = v ? 3'(i) : 3'(i - 8);
			lg = v ? (c < 3'h3) : ~c[1];
			w = v ? {5'h00, c[0], c[1], ~c[0], c[2] ^ c[0], c}
				: {6'h00, c[0], c[1], ~c[0], c[2] ^ c[0], c[1:0]};
			boot(w, v);
			check("osc mode", {29'h0, v ? m14[c] : m8[c[1:0]]}, {29'h0, mode});
			check("clock out", {31'h0, v && (c == 3'h5 || c == 3'h7)}, {31'h0, co});
			check("port bit", {31'h0, v ? (c == 3'h3 || c == 3'h4 || c == 3'h6) : c[1]},
				{31'h0, pb});
			check("freq sel", {31'h0, c[0]}, {31'h0, freq});
			check("reset pin en", {31'h0, c[1]}, {31'h0, rpen});
			check("protect n", {31'h0, ~c[0]}, {31'h0, prot_n});
			check("watchdog en", {31'h0, c[2] ^ c[0]}, {31'h0, wden});
			check("hold time", 32'h1, {31'h0, lg ? (n_rel >= 56 && n_rel <= 84)
				: (n_rel >= 24 && n_rel <= 52)});
			ahb(1'h0, 32'h0, 32'h0, rd);
			check("cfg readback", {20'h0, w | (v ? 12'hf80 : 12'hfc0)}, rd);
		end
	endtask

	task automatic freeze();
		boot(12'h005, 1'h1);
		cfg <= 12'hffa;
		repeat (6) @(posedge clk);
		check("mode frozen", 32'h4, {29'h0, mode});
		check("wdog frozen", 32'h0, {31'h0, wden});
	endtask

	task automatic pin_case(input logic [11:0] w, input logic held, input int lo, input int hi);
		boot(w, 1'h1);
		pin <= 1'h0;
		repeat (10) @(posedge clk);
		check("core on pin", {31'h0, ~held}, {31'h0, core_n});
		check("pin value", {31'h0, held}, {31'h0, rpin});
		pin <= 1'h1;
		wait_rel();
		check("pin release", 32'h1, {31'h0, n_rel >= lo && n_rel <= hi});
	endtask

	task automatic wdog(input logic en, input logic s, input int lo, input int hi);
		int k = 0;
		slow <= s;
		boot({8'h00, en, 3'h4}, 1'h1);
		repeat (96) begin
			@(posedge clk);
			k += int'(wtick);
		end
		check("watchdog ticks", 32'h1, {31'h0, k >= lo && k <= hi});
		slow <= 1'h0;
	endtask

	task automatic bus_ctrl();
		boot(12'h001, 1'h0);
		ahb(1'h0, 32'h40, 32'h0, rd);
		check("unmapped read", 32'h0, rd);
		ahb(1'h1, 32'h8, 32'h1, rd);
		repeat (2) @(posedge clk);
		check("soft reset", 32'h0, {31'h0, core_n});
		wait_rel();
		check("soft hold", 32'h1, {31'h0, n_rel >= 50 && n_rel <= 90});
	endtask

	// ************************************************************
	// main sequence and timeout
	// ************************************************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'h0;
		cfg = 12'h000;
		v14 = 1'h0;
		pin = 1'h1;
		slow = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		decode_all();
		freeze();
		pin_case(12'h021, 1'h1, 56, 90);
		pin_case(12'h024, 1'h1, 0, 8);
		pin_case(12'h004, 1'h0, 0, 0);
		wdog(1'h1, 1'h0, 11, 13);
		wdog(1'h0, 1'h0, 0, 0);
		wdog(1'h1, 1'h1, 3, 5);
		bus_ctrl();
		wrap_up();
	end
endmodule // testbench
